// [src/cswt_pkg.sv]
package cswt_pkg;

   // ==========================================================================
   // Channel geometry
   // ==========================================================================
   localparam int CHANNEL_WIDTH = 16;
   localparam int CASCADE_WIDTH = 2 * CHANNEL_WIDTH;

   // ==========================================================================
   // Count source selection codes
   // ==========================================================================
   localparam logic SRC_SUB_CLOCK     = 1'h0;
   localparam logic SRC_LOW_SPEED_OSC = 1'h1;
   localparam int   SOURCE_COUNT      = 2;

   // ==========================================================================
   // Reset values
   // ==========================================================================
   localparam logic [CHANNEL_WIDTH-1:0] COUNT_RESET_VALUE = 16'hffff;
   localparam logic                     WAKE_RESET_VALUE  = 1'h0;

   // ==========================================================================
   // Timing figures of a 32.768 kHz source
   // ==========================================================================
   // Source frequency in hertz.
   localparam int    SOURCE_FREQ_HZ       = 32768;
   // One source period in nanoseconds, about 30.517 us.
   localparam int    RESOLUTION_PS        = 1000000000 / SOURCE_FREQ_HZ * 1000 / 1000;
   // Low-order channel alone: 65536 source periods, about 2.0 seconds.
   localparam int    LOW_MAX_PERIOD_MS    = (1 << CHANNEL_WIDTH) * 1000 / SOURCE_FREQ_HZ;
   // Cascaded pair: 2**32 source periods, about 36.4 hours.
   localparam real   CASCADE_MAX_HOURS    = 4294967296.0 / SOURCE_FREQ_HZ / 3600.0;
   // Core clock period in nanoseconds.
   localparam int    CORE_CLK_PERIOD_NS   = 4;
   // Core cycles per source period, rounded down (about 7629).
   localparam int    CORE_CYCLES_PER_TICK = 1000000000 / (SOURCE_FREQ_HZ * CORE_CLK_PERIOD_NS);

   // ==========================================================================
   // Carriers
   // ==========================================================================
   // Settings from the power mode controller.
   typedef struct packed {
      logic                     enable;
      logic                     source_select;
      logic [CHANNEL_WIDTH-1:0] low_period;
      logic [CHANNEL_WIDTH-1:0] high_period;
   } cswt_config_type;

   // Count values seen by the power mode controller.
   typedef struct packed {
      logic [CHANNEL_WIDTH-1:0] high_count;
      logic [CHANNEL_WIDTH-1:0] low_count;
   } cswt_count_type;

endpackage

// [src/cswt_channel.sv]
module cswt_channel
   import cswt_pkg::*;
#(
   parameter int WIDTH = CHANNEL_WIDTH
)
(
   // Clock and reset.
   input  wire logic             core_clk,
   input  wire logic             rst_n,
   // Control.
   input  wire logic             enable,
   input  wire logic             count_event,
   input  wire logic [WIDTH-1:0] reload_value,
   // State.
   output logic      [WIDTH-1:0] count,
   output logic                  underflow
);

   // ==========================================================================
   // Down counter
   // ==========================================================================
   logic             step;
   logic             at_zero;
   logic [WIDTH-1:0] next_count;

   // A step is taken only on a count event while the channel runs.
   assign step       = enable && count_event;
   assign at_zero    = (count == '0);
   assign next_count = at_zero ? reload_value : WIDTH'(count - 1'b1);

   // Counts down, reloads after zero and flags the pass through zero.
   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         count     <= COUNT_RESET_VALUE[WIDTH-1:0];
         underflow <= 1'b0;
      end
      else
      begin
         if (step)
         begin
            count <= next_count;
         end
         underflow <= step && at_zero;
      end
   end

   // ==========================================================================
   // Checks
   // ==========================================================================
   AST_CHAN_RELOAD: assert property (
      @(posedge core_clk) disable iff (!rst_n)
      (enable && count_event && count == '0) |=> (count == $past(reload_value) && underflow))
      else $error("Channel did not reload after passing zero.");

   AST_CHAN_DECREMENT: assert property (
      @(posedge core_clk) disable iff (!rst_n)
      (enable && count_event && count != '0) |=> (count == WIDTH'($past(count) - 1'b1) && !underflow))
      else $error("Channel did not count down by one.");

   AST_CHAN_HOLD: assert property (
      @(posedge core_clk) disable iff (!rst_n)
      !(enable && count_event) |=> ($stable(count) && !underflow))
      else $error("Channel moved without a count event.");

endmodule

// [src/cswt_wake_timer.sv]
// What this block does
// - Two 16-bit channels chain into one 32-bit counter.
// - Every low-order underflow gives the high-order channel one count event.
// - Low-order source is the sub-clock or the low-speed internal oscillator.
// - High-order underflow raises the event that wakes the processor.
// - Counting goes on while the device is in standby.
// - At 32.768 kHz the low-order channel alone spans about 2.0 seconds.
// - The pair resolves about 30.517 us and spans about 36.4 hours.
// - In standby, counter and wake state are kept, not cleared.
module cswt_wake_timer
   import cswt_pkg::*;
#(
   parameter int WIDTH = CHANNEL_WIDTH
)
(
   // Clock and reset.
   input  wire logic            core_clk,
   input  wire logic            reset_n,
   // Count sources from the oscillators.
   input  wire logic            sub_clock_oscillator,
   input  wire logic            low_speed_internal_oscillator,
   // Power mode controller.
   input  wire cswt_config_type timer_config,
   input  wire logic            standby,
   input  wire logic            wake_ack,
   output logic                 wake_request,
   output logic                 wake_pulse,
   output logic                 low_underflow,
   // Cascaded count value.
   output cswt_count_type       timer_count
);

   // ==========================================================================
   // Reset release
   // ==========================================================================
   logic rst_meta;
   logic rst_n;

   // Reset asserts at once and is released through two flip-flops.
   // Every other register of the block uses this copy, so both channels leave
   // reset on the same edge and neither starts a cycle ahead of the other.
   always_ff @(posedge core_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         rst_meta <= 1'b0;
         rst_n    <= 1'b0;
      end
      else
      begin
         rst_meta <= 1'b1;
         rst_n    <= rst_meta;
      end
   end

   // ==========================================================================
   // Source synchronisers
   // ==========================================================================
   logic [SOURCE_COUNT-1:0] source_pin;
   logic [SOURCE_COUNT-1:0] source_meta;
   logic [SOURCE_COUNT-1:0] source_sync;
   logic [SOURCE_COUNT-1:0] source_late;
   logic [SOURCE_COUNT-1:0] source_level;
   logic [SOURCE_COUNT-1:0] source_rise;

   // Index 0 is the sub-clock, index 1 the low-speed internal oscillator.
   assign source_pin = {low_speed_internal_oscillator, sub_clock_oscillator};

   genvar src;
   generate
      for (src = 0; src < SOURCE_COUNT; src++)
      begin : gen_source
         // Three flip-flops; a change counts once the last two agree.
         // A level that flickers between the last two stages is ignored until it settles.
         always_ff @(posedge core_clk or negedge rst_n)
         begin
            if (!rst_n)
            begin
               source_meta[src]  <= 1'b0;
               source_sync[src]  <= 1'b0;
               source_late[src]  <= 1'b0;
               source_level[src] <= 1'b0;
            end
            else
            begin
               source_meta[src] <= source_pin[src];
               source_sync[src] <= source_meta[src];
               source_late[src] <= source_sync[src];
               if (source_sync[src] == source_late[src])
               begin
                  source_level[src] <= source_late[src];
               end
            end
         end

         // A rising edge of the agreed level is one source tick.
         assign source_rise[src] = (source_sync[src] == source_late[src]) &&
                                   source_late[src] && !source_level[src];
      end
   endgenerate

   // ==========================================================================
   // Count source selection
   // ==========================================================================
   logic low_count_event;
   logic high_count_event;

   // Both sources run in standby, so the standby input gates nothing.
   // A change of source takes effect at once; a tick in flight may be lost
   // or counted twice, so the controller should switch while disabled.
   assign low_count_event  = (timer_config.source_select == SRC_LOW_SPEED_OSC) ?
                             source_rise[SRC_LOW_SPEED_OSC] :
                             source_rise[SRC_SUB_CLOCK];
   // The low-order underflow is the high-order count event.
   assign high_count_event = low_underflow;

   // ==========================================================================
   // Cascaded channels
   // ==========================================================================
   logic             high_underflow;
   logic [WIDTH-1:0] low_count_value;
   logic [WIDTH-1:0] high_count_value;

   // Low-order channel: one step per source tick, about 30.517 us each.
   cswt_channel #(
      .WIDTH        (WIDTH)
   ) low_order_timer_channel (
      .core_clk     (core_clk),
      .rst_n        (rst_n),
      .enable       (timer_config.enable),
      .count_event  (low_count_event),
      .reload_value (timer_config.low_period[WIDTH-1:0]),
      .count        (low_count_value),
      .underflow    (low_underflow)
   );

   // High-order channel: one step per low-order underflow.
   cswt_channel #(
      .WIDTH        (WIDTH)
   ) high_order_timer_channel (
      .core_clk     (core_clk),
      .rst_n        (rst_n),
      .enable       (timer_config.enable),
      .count_event  (high_count_event),
      .reload_value (timer_config.high_period[WIDTH-1:0]),
      .count        (high_count_value),
      .underflow    (high_underflow)
   );

   // The channel counts sit in the low bits of each half of the carrier.
   assign timer_count = {CHANNEL_WIDTH'(high_count_value), CHANNEL_WIDTH'(low_count_value)};

   // ==========================================================================
   // Wake event
   // ==========================================================================
   logic next_wake_request;

   // A new underflow wins over an acknowledge in the same cycle.
   assign next_wake_request = high_underflow || (wake_request && !wake_ack);

   // The request holds through standby until the controller acknowledges it.
   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         wake_request <= WAKE_RESET_VALUE;
         wake_pulse   <= 1'b0;
      end
      else
      begin
         wake_request <= next_wake_request;
         wake_pulse   <= high_underflow;
      end
   end

   // ==========================================================================
   // Checks
   // ==========================================================================
   AST_CASCADE_STEP: assert property (
      @(posedge core_clk) disable iff (!rst_n)
      (low_underflow && timer_config.enable && high_count_value != '0) |=>
      (high_count_value == WIDTH'($past(high_count_value) - 1'b1)))
      else $error("High-order channel missed a low-order underflow.");

   AST_WAKE_RAISE: assert property (
      @(posedge core_clk) disable iff (!rst_n)
      high_underflow |=> (wake_pulse && wake_request))
      else $error("High-order underflow did not raise the wake event.");

   AST_WAKE_HOLD: assert property (
      @(posedge core_clk) disable iff (!rst_n)
      (wake_request && !wake_ack) |=> wake_request)
      else $error("Wake request dropped without acknowledge.");

   AST_WAKE_CLEAR: assert property (
      @(posedge core_clk) disable iff (!rst_n)
      (wake_request && wake_ack && !high_underflow) |=> !wake_request)
      else $error("Wake request stayed after acknowledge.");

   AST_WAKE_PULSE_ONLY: assert property (
      @(posedge core_clk) disable iff (!rst_n)
      !high_underflow |=> !wake_pulse)
      else $error("Wake pulse without a high-order underflow.");

   AST_WAKE_NO_STRAY: assert property (
      @(posedge core_clk) disable iff (!rst_n)
      (!wake_request && !high_underflow) |=> !wake_request)
      else $error("Wake request rose without a high-order underflow.");

   AST_SOURCE_SELECT: assert property (
      @(posedge core_clk) disable iff (!rst_n)
      (timer_config.enable && !source_rise[timer_config.source_select]) |=> $stable(low_count_value))
      else $error("Low-order channel moved without a tick of the selected source.");

   AST_STANDBY_COUNT: assert property (
      @(posedge core_clk) disable iff (!rst_n)
      (standby && timer_config.enable && low_count_event && low_count_value != '0) |=>
      (low_count_value == WIDTH'($past(low_count_value) - 1'b1)))
      else $error("Counting stopped in standby.");

endmodule

// [tb/cswt_source_model.sv]
module cswt_source_model
   import cswt_pkg::*;
#(
   parameter int SUB_HALF = 32,
   parameter int LSO_HALF = 40
)
(
   // Clock.
   input  wire logic       core_clk,
   // Oscillator and controller settings.
   input  wire logic       run_sub,
   input  wire logic       run_lso,
   input  wire logic [7:0] ack_delay,
   // Wake handshake.
   input  wire logic       wake_request,
   output logic            wake_ack,
   // Oscillator pins.
   output logic            sub_clock_oscillator,
   output logic            low_speed_internal_oscillator
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] wait_cnt;
   // =========================================================
   // Oscillators
   // A stopped oscillator stands low, so no stray edge is seen.
   initial
   begin
      sub_clock_oscillator = 1'b0;
      #1;
      forever
      begin
         #(SUB_HALF);
         sub_clock_oscillator = run_sub & ~sub_clock_oscillator;
      end
   end
   // The low-speed oscillator runs out of phase with the sub-clock.
   initial
   begin
      low_speed_internal_oscillator = 1'b0;
      #3;
      forever
      begin
         #(LSO_HALF);
         low_speed_internal_oscillator = run_lso & ~low_speed_internal_oscillator;
      end
   end
   // =========================================================
   // Power mode controller
   // It acknowledges a wake after ack_delay cycles and holds it until the request drops.
   initial
   begin
      wake_ack = 1'b0;
      wait_cnt = 8'h00;
   end
   always @(negedge core_clk)
   begin
      if (wake_request !== 1'b1)
      begin
         wake_ack <= 1'b0;
         wait_cnt <= 8'h00;
      end
      else if (wait_cnt >= ack_delay)
         wake_ack <= 1'b1;
      else
         wait_cnt <= wait_cnt + 8'h01;
   end
endmodule

// [tb/tb.sv]
module tb
   import cswt_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int W = 4;
   logic            core_clk, reset_n, standby, run_sub, run_lso, sub_osc, lso_osc;
   logic            wake_ack, wake_request, wake_pulse, low_underflow;
   logic [7:0]      ack_delay;
   cswt_config_type cfg;
   cswt_count_type  cnt, held;
   int              n_fail, samples_checked;
   realtime         last_t;

   cswt_wake_timer #(.WIDTH(W)) cswt_wake_timer_inst (.core_clk(core_clk), .reset_n(reset_n),
      .sub_clock_oscillator(sub_osc), .low_speed_internal_oscillator(lso_osc), .timer_config(cfg),
      .standby(standby), .wake_ack(wake_ack), .wake_request(wake_request), .wake_pulse(wake_pulse),
      .low_underflow(low_underflow), .timer_count(cnt));
   cswt_source_model cswt_source_model_inst (.core_clk(core_clk), .run_sub(run_sub), .run_lso(run_lso),
      .ack_delay(ack_delay), .wake_request(wake_request), .wake_ack(wake_ack),
      .sub_clock_oscillator(sub_osc), .low_speed_internal_oscillator(lso_osc));

   // =========================================================
   // Clock and checking helpers
   initial
   begin
      core_clk = 1'b0;
      forever #2 core_clk = ~core_clk;
   end
   task automatic note(input bit ok, input string msg);
      samples_checked++;
      if (!ok)
      begin
         n_fail++;
         $display("unexpected at %0t: %s", $time, msg);
      end
   endtask
   task automatic cmp_bit(input logic got, input logic exp, input string msg);
      note(got === exp, msg);
   endtask
   task automatic cmp_val(input logic [15:0] got, input logic [15:0] exp, input string msg);
      note(got === exp, msg);
   endtask
   task automatic cmp_time(input realtime got, input realtime exp, input string msg);
      note(got == exp, msg);
   endtask
   // One low-order underflow: interval, reload, high step and wake handling.
   task automatic step(input realtime per);
      logic [W-1:0] h;
      int i;
      @(negedge core_clk);
      for (i = 0; i < 2000 && low_underflow !== 1'b1; i++)
         @(negedge core_clk);
      cmp_bit(low_underflow, 1'b1, "no low underflow");
      if (per > 0)
         cmp_time($realtime - last_t, per, "underflow interval");
      last_t = $realtime;
      cmp_val(16'(cnt.low_count[W-1:0]), 16'(cfg.low_period[W-1:0]), "low reload");
      h = cnt.high_count[W-1:0];
      @(negedge core_clk);
      cmp_bit(low_underflow, 1'b0, "underflow not a pulse");
      cmp_val(16'(cnt.high_count[W-1:0]), 16'(h == 0 ? cfg.high_period[W-1:0] : h - 1'b1), "high step");
      @(negedge core_clk);
      cmp_bit(wake_pulse, h == 0, "wake pulse");
      if (h == 0)
      begin
         for (i = 0; i < 100 && wake_ack !== 1'b1; i++)
         begin
            cmp_bit(wake_request, 1'b1, "wake not held");
            @(negedge core_clk);
         end
         cmp_bit(wake_request, 1'b0, "wake not cleared");
      end
   endtask
   // =========================================================
   // Scenarios
   task automatic check_reset();
      cmp_val(16'(cnt.low_count[W-1:0]), 16'(COUNT_RESET_VALUE[W-1:0]), "low reset");
      cmp_val(16'(cnt.high_count[W-1:0]), 16'(COUNT_RESET_VALUE[W-1:0]), "high reset");
      cmp_bit(wake_request | wake_pulse | low_underflow, WAKE_RESET_VALUE, "flags in reset");
   endtask
   // Cascade on the sub-clock through two wake events, slow acknowledge.
   task automatic run_cascade();
      cfg = '{enable: 1'b1, source_select: SRC_SUB_CLOCK, low_period: 16'h0003, high_period: 16'h0002};
      step(0.0);
      repeat (20) step(256.0);
   endtask
   // Counts freeze while disabled and while the selected source is stopped.
   task automatic check_hold();
      cfg.enable = 1'b0;
      repeat (10) @(negedge core_clk);
      held = cnt;
      repeat (60) @(negedge core_clk);
      cmp_val(cnt.low_count, held.low_count, "counts moved while disabled");
      cmp_val(cnt.high_count, held.high_count, "high count moved while disabled");
      run_sub = 1'b0;
      repeat (10) @(negedge core_clk);
      cfg.enable = 1'b1;
      repeat (10) @(negedge core_clk);
      held = cnt;
      repeat (80) @(negedge core_clk);
      cmp_val(cnt.low_count, held.low_count, "unselected source counted");
   endtask
   // Low-speed oscillator in standby with a prompt acknowledge.
   task automatic run_standby();
      ack_delay = 8'h00;
      standby = 1'b1;
      cfg.source_select = SRC_LOW_SPEED_OSC;
      step(0.0);
      repeat (4) step(320.0);
   endtask
   task automatic print_verdict();
      if (n_fail == 0 && samples_checked > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   // =========================================================
   // Main sequence and watchdog
   initial
   begin
      reset_n = 1'b0;
      standby = 1'b0;
      run_sub = 1'b1;
      run_lso = 1'b1;
      ack_delay = 8'h1e;
      cfg = '0;
      n_fail = 0;
      samples_checked = 0;
      last_t = 0.0;
      repeat (10) @(negedge core_clk);
      check_reset();
      repeat (10) @(negedge core_clk);
      reset_n = 1'b1;
      repeat (5) @(negedge core_clk);
      run_cascade();
      check_hold();
      run_standby();
      print_verdict();
   end
   initial
   begin
      repeat (10000) @(posedge core_clk);
      n_fail++;
      print_verdict();
   end
endmodule
